// >>> pom_port_pin_override_mux.sv
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none

`include "pom_params.svh"

module pom_port_pin_override_mux (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Sleep controller clamp, shared by all ports.
  input wire logic i_sleep_clamp,
  // Port A pads.
  input wire logic [7:0] i_pa_pad_in,
  output logic [7:0] o_pa_pad_out,
  output logic [7:0] o_pa_pad_oe,
  output logic [7:0] o_pa_pullup_en,
  output logic [7:0] o_pa_analog_pad_line,
  // General port pads.
  input wire logic [7:0] i_pg_pad_in,
  output logic [7:0] o_pg_pad_out,
  output logic [7:0] o_pg_pad_oe,
  output logic [7:0] o_pg_pullup_en,
  output logic [7:0] o_pg_analog_pad_line,
  // General port overrides from peripherals.
  input wire logic [7:0] i_pg_pullup_override_enable,
  input wire logic [7:0] i_pg_pullup_override_value,
  input wire logic [7:0] i_pg_direction_override_enable,
  input wire logic [7:0] i_pg_direction_override_value,
  input wire logic [7:0] i_pg_pin_value_override_enable,
  input wire logic [7:0] i_pg_pin_value_override_value,
  input wire logic [7:0] i_pg_input_enable_override_enable,
  input wire logic [7:0] i_pg_input_enable_override_value,
  // General port digital taps to peripherals.
  output logic [7:0] o_pg_schmitt_input_tap,
  // Misc control bits owned by other blocks.
  output logic [7:0] o_misc_function_control,
  output logic o_global_pullup_off
);

  ////////////////////////////////////////////////////////////////////////////

  pom_pkg::pom_byte_t misc_function_control;
  pom_pkg::pom_byte_t pa_output;
  pom_pkg::pom_byte_t pa_direction;
  pom_pkg::pom_byte_t pg_output;
  pom_pkg::pom_byte_t pg_direction;
  pom_pkg::pom_reg_sel_t reg_sel;
  logic setup_phase;
  logic access_wr;
  logic global_pullup_off;
  logic pa_output_write_strobe;
  logic pa_direction_write_strobe;
  logic pg_output_write_strobe;
  logic pg_direction_write_strobe;
  logic misc_write_strobe;
  logic [7:0] pa_pad_sync;
  logic [7:0] pg_pad_sync;
  logic [7:0] pa_input_enable;
  logic [7:0] pg_input_enable;
  logic [7:0] pa_pin_value;
  logic [7:0] pg_pin_value;
  logic [7:0] next_rbyte;
  logic [15:0] all_dir;
  logic [15:0] all_out;
  logic [15:0] all_pad_in;
  logic [15:0] all_pad_out;
  logic [15:0] all_pad_oe;
  logic [15:0] all_pullup;
  logic [15:0] all_ie;
  logic [15:0] all_tap;
  logic [15:0] ovr_pu_en;
  logic [15:0] ovr_pu_val;
  logic [15:0] ovr_dd_en;
  logic [15:0] ovr_dd_val;
  logic [15:0] ovr_pv_en;
  logic [15:0] ovr_pv_val;
  logic [15:0] ovr_ie_en;
  logic [15:0] ovr_ie_val;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.
  // One select value per register, shared by the strobes, the error
  // flag and the read mux, keeps the three from disagreeing.

  always_comb begin
    case (i_paddr)
      `POM_OFS_MISC: begin
        reg_sel = pom_pkg::POM_SEL_MISC;
      end
      `POM_OFS_PA_OUT: begin
        reg_sel = pom_pkg::POM_SEL_PA_OUT;
      end
      `POM_OFS_PA_DIR: begin
        reg_sel = pom_pkg::POM_SEL_PA_DIR;
      end
      `POM_OFS_PA_PIN: begin
        reg_sel = pom_pkg::POM_SEL_PA_PIN;
      end
      `POM_OFS_PG_OUT: begin
        reg_sel = pom_pkg::POM_SEL_PG_OUT;
      end
      `POM_OFS_PG_DIR: begin
        reg_sel = pom_pkg::POM_SEL_PG_DIR;
      end
      `POM_OFS_PG_PIN: begin
        reg_sel = pom_pkg::POM_SEL_PG_PIN;
      end
      default: begin
        reg_sel = pom_pkg::POM_SEL_NONE;
      end
    endcase
  end

  // Every access completes in its first access cycle. No register here
  // needs more than one cycle to read or write, so wait states would
  // only cost bus bandwidth.
  assign o_pready = 1'b1;
  assign setup_phase = i_psel && !i_penable;
  assign access_wr = i_psel && i_penable && i_pwrite;

  // Unmapped addresses and writes to the pin registers are errors.
  // The write is dropped as well, so a stray store leaves the pads alone.
  assign o_pslverr = i_psel && i_penable &&
                     ((reg_sel == pom_pkg::POM_SEL_NONE) ||
                      (i_pwrite && (reg_sel == pom_pkg::POM_SEL_PA_PIN)) ||
                      (i_pwrite && (reg_sel == pom_pkg::POM_SEL_PG_PIN)));

  // One write strobe per output and direction register, shared by all its pins.
  assign misc_write_strobe = access_wr &&
                             (reg_sel == pom_pkg::POM_SEL_MISC);
  assign pa_output_write_strobe = access_wr &&
                                  (reg_sel == pom_pkg::POM_SEL_PA_OUT);
  assign pa_direction_write_strobe = access_wr &&
                                     (reg_sel == pom_pkg::POM_SEL_PA_DIR);
  assign pg_output_write_strobe = access_wr &&
                                  (reg_sel == pom_pkg::POM_SEL_PG_OUT);
  assign pg_direction_write_strobe = access_wr &&
                                     (reg_sel == pom_pkg::POM_SEL_PG_DIR);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // Only the pull-up off bit acts inside this block; the other bits
  // are kept for the blocks that own them.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      misc_function_control <= `POM_MISC_RST;
    end else if (misc_write_strobe) begin
      misc_function_control <= i_pwdata[7:0];
    end
  end

  // Zero direction and output bits leave pins tri-stated after reset.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pa_output <= `POM_PORT_RST;
      pa_direction <= `POM_PORT_RST;
    end else begin
      if (pa_output_write_strobe) begin
        pa_output <= i_pwdata[7:0];
      end
      if (pa_direction_write_strobe) begin
        pa_direction <= i_pwdata[7:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pg_output <= `POM_PORT_RST;
      pg_direction <= `POM_PORT_RST;
    end else begin
      if (pg_output_write_strobe) begin
        pg_output <= i_pwdata[7:0];
      end
      if (pg_direction_write_strobe) begin
        pg_direction <= i_pwdata[7:0];
      end
    end
  end

  // One bit, shared by every pin of both ports.
  assign global_pullup_off =
    misc_function_control[`POM_PUD_BIT];
  assign o_global_pullup_off = global_pullup_off;
  assign o_misc_function_control = misc_function_control;

  ////////////////////////////////////////////////////////////////////////////
  // Pin read path.

  pom_sync2 u_pa_sync (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_async(i_pa_pad_in),
    .o_sync(pa_pad_sync)
  );

  pom_sync2 u_pg_sync (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_async(i_pg_pad_in),
    .o_sync(pg_pad_sync)
  );

  // A pad change shows in a pin register read after the two synchroniser
  // edges and the capture edge of the read.
  // The clamp is applied after the synchroniser so that no gate looks
  // at the raw pad ahead of it; the enable is itself synchronous.
  assign pa_pin_value = pa_pad_sync & pa_input_enable;
  assign pg_pin_value = pg_pad_sync & pg_input_enable;

  always_comb begin
    case (reg_sel)
      pom_pkg::POM_SEL_MISC: begin
        next_rbyte = misc_function_control;
      end
      pom_pkg::POM_SEL_PA_OUT: begin
        next_rbyte = pa_output;
      end
      pom_pkg::POM_SEL_PA_DIR: begin
        next_rbyte = pa_direction;
      end
      pom_pkg::POM_SEL_PA_PIN: begin
        next_rbyte = pa_pin_value;
      end
      pom_pkg::POM_SEL_PG_OUT: begin
        next_rbyte = pg_output;
      end
      pom_pkg::POM_SEL_PG_DIR: begin
        next_rbyte = pg_direction;
      end
      pom_pkg::POM_SEL_PG_PIN: begin
        next_rbyte = pg_pin_value;
      end
      default: begin
        next_rbyte = `POM_PORT_RST;
      end
    endcase
  end

  // Read data is captured in the setup cycle so it leaves a flip-flop.
  // A pin register is therefore sampled one cycle before the access edge.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_prdata <= `POM_RDATA_RST;
    end else if (setup_phase && !i_pwrite) begin
      o_prdata <= {24'h00_0000, next_rbyte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin override multiplexing.

  // Port A has no digital alternate function, so its overrides are tied
  // low; the general port takes whatever its peripherals drive.
  // Overrides act combinationally, so a peripheral owns its pin in the
  // same cycle in which it raises the enable.
  assign ovr_pu_en = {i_pg_pullup_override_enable, 8'h00};
  assign ovr_pu_val = {i_pg_pullup_override_value, 8'h00};
  assign ovr_dd_en = {i_pg_direction_override_enable, 8'h00};
  assign ovr_dd_val = {i_pg_direction_override_value, 8'h00};
  assign ovr_pv_en = {i_pg_pin_value_override_enable, 8'h00};
  assign ovr_pv_val = {i_pg_pin_value_override_value, 8'h00};
  assign ovr_ie_en = {i_pg_input_enable_override_enable, 8'h00};
  assign ovr_ie_val = {i_pg_input_enable_override_value, 8'h00};

  assign all_dir = {pg_direction, pa_direction};
  assign all_out = {pg_output, pa_output};
  assign all_pad_in = {i_pg_pad_in, i_pa_pad_in};

  // Port A cells are the same cells, only with their overrides held low.
  for (genvar g = 0; g < 2 * `POM_PINS; g++) begin : g_pin
    pom_pin_cell u_cell (
      .i_direction_bit(all_dir[g]),
      .i_output_bit(all_out[g]),
      .i_global_pullup_off(global_pullup_off),
      .i_sleep_clamp(i_sleep_clamp),
      .i_pullup_override_enable(ovr_pu_en[g]),
      .i_pullup_override_value(ovr_pu_val[g]),
      .i_direction_override_enable(ovr_dd_en[g]),
      .i_direction_override_value(ovr_dd_val[g]),
      .i_pin_value_override_enable(ovr_pv_en[g]),
      .i_pin_value_override_value(ovr_pv_val[g]),
      .i_input_enable_override_enable(ovr_ie_en[g]),
      .i_input_enable_override_value(ovr_ie_val[g]),
      .i_pad_in(all_pad_in[g]),
      .o_pad_out(all_pad_out[g]),
      .o_pad_oe(all_pad_oe[g]),
      .o_pullup_en(all_pullup[g]),
      .o_input_enable(all_ie[g]),
      .o_schmitt_input_tap(all_tap[g])
    );
  end

  assign o_pa_pad_out = all_pad_out[7:0];
  assign o_pa_pad_oe = all_pad_oe[7:0];
  assign o_pa_pullup_en = all_pullup[7:0];
  assign pa_input_enable = all_ie[7:0];
  assign o_pg_pad_out = all_pad_out[15:8];
  assign o_pg_pad_oe = all_pad_oe[15:8];
  assign o_pg_pullup_en = all_pullup[15:8];
  assign pg_input_enable = all_ie[15:8];
  // The Port A taps are left open: no peripheral takes a digital input
  // from those pins.
  assign o_pg_schmitt_input_tap = all_tap[15:8];

  ////////////////////////////////////////////////////////////////////////////
  // Analog lines.

  // A pure wire from the pad: no override or clamp stands in between,
  // which is why Port A outputs switching mid-conversion disturb it.
  assign o_pa_analog_pad_line = i_pa_pad_in;
  assign o_pg_analog_pad_line = i_pg_pad_in;

endmodule

`default_nettype wire

// >>> pom_params.svh
`ifndef POM_PARAMS_SVH
`define POM_PARAMS_SVH

// Register byte offsets on the APB bus.
`define POM_OFS_MISC 8'h00
`define POM_OFS_PA_OUT 8'h04
`define POM_OFS_PA_DIR 8'h08
`define POM_OFS_PA_PIN 8'h0C
`define POM_OFS_PG_OUT 8'h10
`define POM_OFS_PG_DIR 8'h14
`define POM_OFS_PG_PIN 8'h18

// Field positions and reset values.
`define POM_PUD_BIT 2
`define POM_MISC_RST 8'h00
`define POM_PORT_RST 8'h00
`define POM_RDATA_RST 32'h0000_0000

// Pins per port.
`define POM_PINS 8

`endif

// >>> pom_pkg.sv
package pom_pkg;

  typedef logic [7:0] pom_byte_t;

  typedef enum logic [2:0] {
    POM_SEL_NONE = 3'b000,
    POM_SEL_MISC = 3'b001,
    POM_SEL_PA_OUT = 3'b010,
    POM_SEL_PA_DIR = 3'b011,
    POM_SEL_PA_PIN = 3'b100,
    POM_SEL_PG_OUT = 3'b101,
    POM_SEL_PG_DIR = 3'b110,
    POM_SEL_PG_PIN = 3'b111
  } pom_reg_sel_t;

endpackage

// >>> pom_sync2.sv
`timescale 1ns/10ps
`default_nettype none

`include "pom_params.svh"

module pom_sync2 (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Asynchronous pad levels in, settled levels out.
  input wire logic [7:0] i_async,
  output logic [7:0] o_sync
);

  logic [7:0] stage1;

  // The first stage is read by the second stage only.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      stage1 <= `POM_PORT_RST;
      o_sync <= `POM_PORT_RST;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

`default_nettype wire

// >>> pom_pin_cell.sv
`timescale 1ns/10ps
`default_nettype none

module pom_pin_cell (
  // Register bits and shared controls.
  input wire logic i_direction_bit,
  input wire logic i_output_bit,
  input wire logic i_global_pullup_off,
  input wire logic i_sleep_clamp,
  // Override signals from the owning peripheral.
  input wire logic i_pullup_override_enable,
  input wire logic i_pullup_override_value,
  input wire logic i_direction_override_enable,
  input wire logic i_direction_override_value,
  input wire logic i_pin_value_override_enable,
  input wire logic i_pin_value_override_value,
  input wire logic i_input_enable_override_enable,
  input wire logic i_input_enable_override_value,
  // Pad side.
  input wire logic i_pad_in,
  output logic o_pad_out,
  output logic o_pad_oe,
  output logic o_pullup_en,
  output logic o_input_enable,
  output logic o_schmitt_input_tap
);

  logic base_pullup;
  logic base_input_enable;

  // Plain pull-up only for {dir, out, off} = 3'b010.
  assign base_pullup = !i_direction_bit && i_output_bit &&
                       !i_global_pullup_off;

  assign o_pullup_en = i_pullup_override_enable ?
                       i_pullup_override_value :
                       base_pullup;

  assign o_pad_oe = i_direction_override_enable ?
                    i_direction_override_value :
                    i_direction_bit;

  // Value is only meaningful while the driver is enabled.
  assign o_pad_out = o_pad_oe && (i_pin_value_override_enable ?
                     i_pin_value_override_value :
                     i_output_bit);

  assign base_input_enable = !i_sleep_clamp;

  assign o_input_enable = i_input_enable_override_enable ?
                          i_input_enable_override_value :
                          base_input_enable;

  // Clamped to ground ahead of the trigger, not synchronised here.
  assign o_schmitt_input_tap = i_pad_in && o_input_enable;

endmodule

`default_nettype wire

// >>> pom_mux_chk.sv
`timescale 1ns/10ps
`default_nettype none

module pom_mux_chk (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Register bus.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic [7:0] o_misc_function_control,
  input wire logic o_global_pullup_off,
  // Pins and overrides.
  input wire logic i_sleep_clamp,
  input wire logic [7:0] i_pa_pad_in,
  input wire logic [7:0] o_pa_pad_oe,
  input wire logic [7:0] o_pa_analog_pad_line,
  input wire logic [7:0] i_pg_pad_in,
  input wire logic [7:0] o_pg_pad_out,
  input wire logic [7:0] o_pg_pad_oe,
  input wire logic [7:0] o_pg_pullup_en,
  input wire logic [7:0] o_pg_schmitt_input_tap,
  input wire logic [7:0] i_pg_pullup_override_enable,
  input wire logic [7:0] i_pg_pullup_override_value,
  input wire logic [7:0] i_pg_direction_override_enable,
  input wire logic [7:0] i_pg_direction_override_value,
  input wire logic [7:0] i_pg_pin_value_override_enable,
  input wire logic [7:0] i_pg_pin_value_override_value,
  input wire logic [7:0] i_pg_input_enable_override_enable,
  input wire logic [7:0] i_pg_input_enable_override_value
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  logic misc_wr;
  assign misc_wr = i_psel && i_penable && i_pwrite && i_paddr == 8'h00;
  ////////////////////////////////////////
  property p_pu_ovr;
    (o_pg_pullup_en & i_pg_pullup_override_enable) ==
      (i_pg_pullup_override_value & i_pg_pullup_override_enable);
  endproperty
  a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up ovr");
  property p_dir_ovr;
    (o_pg_pad_oe & i_pg_direction_override_enable) ==
      (i_pg_direction_override_value & i_pg_direction_override_enable);
  endproperty
  a_dir_ovr: assert property (p_dir_ovr) else $error("dir ovr");
  property p_val_ovr;
    (o_pg_pad_out & o_pg_pad_oe & i_pg_pin_value_override_enable) ==
      (i_pg_pin_value_override_value & o_pg_pad_oe &
       i_pg_pin_value_override_enable);
  endproperty
  a_val_ovr: assert property (p_val_ovr) else $error("value ovr");
  property p_pud;
    o_global_pullup_off |->
      (o_pg_pullup_en & ~i_pg_pullup_override_enable) == 8'h00;
  endproperty
  a_pud: assert property (p_pud) else $error("pull-up not off");
  property p_analog;
    o_pa_analog_pad_line == i_pa_pad_in;
  endproperty
  a_analog: assert property (p_analog) else $error("analog line");
  property p_tap;
    o_pg_schmitt_input_tap == (i_pg_pad_in &
      ((i_pg_input_enable_override_enable &
        i_pg_input_enable_override_value) |
       (~i_pg_input_enable_override_enable & {8{~i_sleep_clamp}})));
  endproperty
  a_tap: assert property (p_tap) else $error("input tap");
  property p_misc_wr;
    misc_wr |=> o_misc_function_control == $past(i_pwdata[7:0]);
  endproperty
  a_misc_wr: assert property (p_misc_wr) else $error("misc write");
  property p_misc_hold;
    !misc_wr |=> $stable(o_misc_function_control);
  endproperty
  a_misc_hold: assert property (p_misc_hold) else $error("drift");
  property p_rst;
    $fell(i_srst) |-> o_misc_function_control == 8'h00 && o_pa_pad_oe == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_pud: cover property (misc_wr && i_pwdata[2]);
  c_clamp: cover property (i_sleep_clamp && o_pg_schmitt_input_tap != 8'h00);
  c_val: cover property
    ((o_pg_pad_oe & i_pg_pin_value_override_enable) != 8'h00);
endmodule

bind pom_port_pin_override_mux pom_mux_chk u_pom_mux_chk (.*);

`default_nettype wire

// >>> pom_periph_model.sv
`timescale 1ns/10ps
`default_nettype none

module pom_periph_model (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Override pattern.
  input wire logic i_load,
  input wire logic [63:0] i_word,
  output logic [63:0] o_overrides,
  // Raw pin tap.
  input wire logic [7:0] i_tap,
  output logic [7:0] o_tap_sync
);
  logic [7:0] tap_meta;
  // Overrides idle low so that unclaimed pins act as plain I/O.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) o_overrides <= '0;
    else if (i_load) o_overrides <= i_word;
  end
  // The tap is unsynchronised, so two stages guard against metastability.
  always_ff @(posedge i_sys_clk) begin
    tap_meta <= i_tap;
    o_tap_sync <= tap_meta;
  end
endmodule

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic i_sys_clk = 1'b0, i_srst = 1'b1, ld = 1'b0, e;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic i_sleep_clamp = 1'b0;
  logic [7:0] i_paddr = 8'h00, i_pa_pad_in = 8'h00, i_pg_pad_in = 8'h00;
  logic [31:0] i_pwdata = '0, o_prdata, r, d, rd;
  logic [63:0] w = '0;
  logic o_pready, o_pslverr, o_global_pullup_off;
  logic [7:0] o_pa_pad_out, o_pa_pad_oe, o_pa_pullup_en, o_pa_analog_pad_line;
  logic [7:0] o_pg_pad_out, o_pg_pad_oe, o_pg_pullup_en, o_pg_analog_pad_line;
  logic [7:0] o_pg_schmitt_input_tap, o_misc_function_control, tsync;
  wire logic [63:0] ov;
  wire logic [7:0] i_pg_pullup_override_enable, i_pg_pullup_override_value;
  wire logic [7:0] i_pg_direction_override_enable;
  wire logic [7:0] i_pg_direction_override_value;
  wire logic [7:0] i_pg_pin_value_override_enable;
  wire logic [7:0] i_pg_pin_value_override_value;
  wire logic [7:0] i_pg_input_enable_override_enable;
  wire logic [7:0] i_pg_input_enable_override_value;
  logic [7:0] m [5];
  logic [7:0] ad [8] = '{8'h00, 8'h04, 8'h08, 8'h10,
                         8'h14, 8'h0C, 8'h18, 8'h1C};
  int miscompares = 0, comparisons = 0, seed = 87931, k;
  assign {i_pg_input_enable_override_value, i_pg_input_enable_override_enable,
          i_pg_pin_value_override_value, i_pg_pin_value_override_enable,
          i_pg_direction_override_value, i_pg_direction_override_enable,
          i_pg_pullup_override_value, i_pg_pullup_override_enable} = ov;
  pom_port_pin_override_mux u_pom_port_pin_override_mux (.*);
  pom_periph_model u_pom_periph_model (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_load(ld), .i_word(w), .o_overrides(ov),
    .i_tap(o_pg_schmitt_input_tap), .o_tap_sync(tsync));
  initial forever #2.5 i_sys_clk = ~i_sys_clk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // The slave never stretches the access phase; the task still polls o_pready, bounded only by the watchdog.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] dat);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= dat;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (o_pready !== 1'b1) begin
      @(posedge i_sys_clk);
    end
    rd = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  function automatic logic [7:0] ien();
    return (w[55:48] & w[63:56]) | (~w[55:48] & {8{~i_sleep_clamp}});
  endfunction
  task automatic rdchk(input int j);
    logic [7:0] x;
    apb(1'b0, ad[j], '0);
    case (j)
      5: x = i_pa_pad_in & {8{~i_sleep_clamp}};
      6: x = i_pg_pad_in & ien();
      7: x = 8'h00;
      default: x = m[j];
    endcase
    chk(e, j == 7);
    chk(rd, {24'h00_0000, x});
  endtask
  task automatic pads();
    logic [7:0] oe, pu, pv, up;
    pu = {8{~m[0][2]}};
    oe = (w[23:16] & w[31:24]) | (~w[23:16] & m[4]);
    pv = (w[39:32] & w[47:40]) | (~w[39:32] & m[3]);
    up = (w[7:0] & w[15:8]) | (~w[7:0] & ~m[4] & m[3] & pu);
    chk(o_pa_pad_oe, m[2]);
    chk(o_pa_pad_out, m[2] & m[1]);
    chk(o_pa_pullup_en, ~m[2] & m[1] & pu);
    chk(o_pa_analog_pad_line, i_pa_pad_in);
    chk(o_pg_analog_pad_line, i_pg_pad_in);
    chk(o_pg_pad_oe, oe);
    chk(o_pg_pad_out, oe & pv);
    chk(o_pg_pullup_en, up);
    chk(o_pg_schmitt_input_tap, i_pg_pad_in & ien());
    chk(tsync, i_pg_pad_in & ien());
    chk(o_global_pullup_off, m[0][2]);
    chk(o_misc_function_control, m[0]);
  endtask
  ////////////////////////////////////////
  initial begin
    for (int i = 0; i < 5; i++) m[i] = 8'h00;
    repeat (5) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1 pads();
    for (int j = 0; j < 8; j++) rdchk(j);
    // The first rounds keep overrides off to exercise plain pin behaviour.
    for (int t = 0; t < 80; t++) begin
      r = $random(seed);
      @(posedge i_sys_clk);
      ld <= 1'b1;
      w <= (t < 16) ? '0 : {$random(seed), $random(seed)};
      i_pa_pad_in <= r[7:0];
      i_pg_pad_in <= r[15:8];
      i_sleep_clamp <= r[16];
      @(posedge i_sys_clk);
      ld <= 1'b0;
      k = $unsigned($random(seed)) % 8;
      d = $random(seed);
      apb(1'b1, ad[k], d);
      chk(e, k > 4);
      if (k < 5) m[k] = d[7:0];
      rdchk($unsigned($random(seed)) % 8);
      repeat (2) @(posedge i_sys_clk);
      #1 pads();
    end
    @(posedge i_sys_clk);
    i_srst <= 1'b1;
    @(posedge i_sys_clk);
    i_srst <= 1'b0;
    for (int i = 0; i < 5; i++) m[i] = 8'h00;
    w = '0;
    repeat (3) @(posedge i_sys_clk);
    #1 pads();
    complete_run();
  end
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule

`default_nettype wire
